// ### bench/acwe_checker.sv
// Purpose: Port checks for acwe_ctrl
// Assumes: Settings are tracked from acknowledged bus writes
// Notes: Tracked settings lag the design's own by one cycle
`timescale 1ns/100ps
`default_nettype none
`include "acwe_defs.vh"
module acwe_checker
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Converter and events
  input wire logic smp_valid_i,
  input wire logic [6:0] positive_input_select_o,
  input wire logic [6:0] negative_input_select_o,
  input wire logic conv_busy_o,
  input wire logic sample_o,
  input wire logic start_event_i,
  input wire logic result_ready_event_o,
  input wire logic irq_o
);
  logic en_q, diff_q, ev_q;
  logic [1:0] ien_q;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q <= 1'b0;
      diff_q <= 1'b0;
      ev_q <= 1'b0;
      ien_q <= 2'h0;
    end
    else if (wr)
    begin
      if (wb_adr_i == `ACWE_ADR_CTRL)
      begin
        en_q <= wb_dat_i[`ACWE_CTRL_ENABLE];
        diff_q <= wb_dat_i[`ACWE_CTRL_DIFF];
      end
      if (wb_adr_i == `ACWE_ADR_EVCTL)
        ev_q <= wb_dat_i[0];
      if (wb_adr_i == `ACWE_ADR_IEN)
        ien_q <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus not answered");
  a_sel_frozen: assert property
    (sample_o && $past(sample_o) |-> $stable(positive_input_select_o)
     && $stable(negative_input_select_o))
    else $error("selection moved while sampling");
  a_single_neg: assert property
    (!diff_q && !$past(diff_q) && !conv_busy_o
     |-> negative_input_select_o == 7'h00)
    else $error("negative select used in single mode");
  a_cmd_start: assert property
    (wr && wb_adr_i == `ACWE_ADR_CMD && wb_dat_i[0] && en_q && !conv_busy_o
     |=> conv_busy_o)
    else $error("start bit did not start");
  a_event_start: assert property
    ($rose(start_event_i) && ev_q && en_q && !conv_busy_o
     |-> ##[1:3] conv_busy_o)
    else $error("start event ignored");
  a_event_pulse: assert property
    (result_ready_event_o |=> !result_ready_event_o)
    else $error("ready event too long");
  a_event_cause: assert property
    (result_ready_event_o |-> $past(smp_valid_i) && $past(conv_busy_o))
    else $error("ready event without sample");
  a_irq_raise: assert property
    (result_ready_event_o && ien_q[0] |-> ##[0:1] irq_o)
    else $error("irq not raised");
  a_irq_masked: assert property
    (!wr && ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> !irq_o)
    else $error("irq while masked");
endmodule // acwe_checker
bind acwe_ctrl acwe_checker i_acwe_checker
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i),
  .positive_input_select_o(positive_input_select_o),
  .negative_input_select_o(negative_input_select_o),
  .conv_busy_o(conv_busy_o), .sample_o(sample_o),
  .start_event_i(start_event_i),
  .result_ready_event_o(result_ready_event_o), .irq_o(irq_o)
);
`default_nettype wire

// ### bench/acwe_core_model.sv
// Purpose: Converter core stand-in for acwe_ctrl
// Assumes: One sample per conversion phase, answer DLY cycles late
// Notes: Data shows inverted junk outside the valid cycle
`timescale 1ns/100ps
`default_nettype none
module acwe_core_model
#(
  parameter int DLY = 3
)
(
  // Clock
  input wire logic clk_i,
  // Converter side
  input wire logic conv_busy_i,
  input wire logic sample_i,
  input wire logic [11:0] value_i,
  output logic valid_o,
  output logic [11:0] data_o
);
  int cnt = 0;
  logic hit;
  assign hit = conv_busy_i && !sample_i && cnt == 14 + DLY;
  initial
  begin
    valid_o = 1'b0;
    data_o = 12'h000;
  end
  always @(posedge clk_i)
  begin
    cnt <= (!conv_busy_i || sample_i) ? 0 : cnt + 1;
    valid_o <= hit;
    data_o <= hit ? value_i : ~data_o;
  end
endmodule // acwe_core_model
`default_nettype wire

// ### bench/adc_channel_window_event_ctrl_bench.sv
// Purpose: Self-checking bench for acwe_ctrl
// Assumes: Core model answers every conversion phase
// Notes: Read data is queued by the driver and checked by a monitor
`timescale 1ns/100ps
`default_nettype none
`include "acwe_defs.vh"
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module adc_channel_window_event_ctrl_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic start_event_i = 1'b0;
  logic [11:0] smp_val = 12'h000;
  logic [31:0] lfsr_q = 32'h99A5;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, smp_valid_i, conv_busy_o, sample_o, irq_o, rdy;
  logic [11:0] smp_data_i;
  logic [6:0] pos_o, neg_o;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int failures = 0;
  int checks_done = 0;
  int ticks = 0;
  // Sensor input code is arbitrary
  localparam logic [6:0] TEMP_SEL = 7'h42;
  acwe_ctrl i_acwe_ctrl
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
    .positive_input_select_o(pos_o), .negative_input_select_o(neg_o),
    .conv_busy_o(conv_busy_o), .sample_o(sample_o),
    .start_event_i(start_event_i), .result_ready_event_o(rdy),
    .irq_o(irq_o)
  );
  acwe_core_model #(.DLY(3)) i_acwe_core_model
  (
    .clk_i(clk_i), .conv_busy_i(conv_busy_o), .sample_i(sample_o),
    .value_i(smp_val), .valid_o(smp_valid_i), .data_o(smp_data_i)
  );
  initial
    forever #4 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Strict compare, signed when differential
  function automatic logic win(input logic [2:0] m, input logic [15:0] r,
                               input logic s);
    logic lt, gt, ins;
    lt = s ? $signed(r) < $signed(16'h0064) : r < 16'h0064;
    gt = s ? $signed(r) > $signed(16'h00C8) : r > 16'h00C8;
    ins = !lt && !gt && r != 16'h0064 && r != 16'h00C8;
    case (m)
      3'h1: return lt;
      3'h2: return gt;
      3'h3: return ins;
      3'h4: return lt || gt;
      default: return 1'b0;
    endcase
  endfunction
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
      failures++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    exp_q.push_back({m, x});
    bus(1'b0, a, 32'h0);
  endtask
  // Start by command or event, move the selection, wait for the result
  task automatic run(input logic [11:0] v, input logic ev,
                     input logic [6:0] p);
    int n;
    n = 0;
    smp_val <= v;
    if (ev)
    begin
      @(posedge clk_i);
      start_event_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd(`ACWE_ADR_CMD, 32'h1, 32'h1);
      start_event_i <= 1'b0;
    end
    else
      wr(`ACWE_ADR_CMD, 32'h1);
    wr(`ACWE_ADR_POS, {25'h0, p});
    while (rdy !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
      failures++;
    rd(`ACWE_ADR_CMD, 32'h0, 32'h1);
  endtask
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      failures++;
      summarize();
    end
  end
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      e = exp_q.pop_front();
      `CHK(wb_dat_o & e[63:32], e[31:0])
    end
  initial
  begin
    logic [11:0] v;
    logic [15:0] r;
    logic [2:0] m;
    logic s;
    int t0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ACWE_ADR_IFLAG, 32'h0, 32'hFFFFFFFF);
    rd(`ACWE_ADR_RESULT, 32'h0, 32'hFFFFFFFF);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(`ACWE_ADR_CTRL, 32'h1);
    wr(`ACWE_ADR_IEN, 32'h3);
    wr(`ACWE_ADR_WLOW, 32'h64);
    wr(`ACWE_ADR_WHIGH, 32'hC8);
    wr(`ACWE_ADR_POS, 32'h5);
    wr(`ACWE_ADR_NEG, 32'h9);
    rd(`ACWE_ADR_WHIGH, 32'hC8, 32'hFFFF);
    `CHK(pos_o, 7'h05)
    `CHK(neg_o, 7'h00)
    wr(`ACWE_ADR_CTRL, 32'h21);
    rd(`ACWE_ADR_CTRL, 32'h21, 32'hFF);
    `CHK(neg_o, 7'h09)
    start_event_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    start_event_i <= 1'b0;
    `CHK(conv_busy_o, 1'b0)
    wr(`ACWE_ADR_EVCTL, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      m = 3'(i % 5);
      s = i >= 5;
      lfsr_q = lfsr(lfsr_q);
      v = 12'h050 + 12'(lfsr_q[7:0] % 160);
      if (s)
        v = v ^ 12'h800;
      r = s ? {{4{v[11]}}, v} : {4'h0, v};
      wr(`ACWE_ADR_CTRL, s ? 32'h21 : 32'h1);
      wr(`ACWE_ADR_WMODE, {29'h0, m});
      wr(`ACWE_ADR_SAMP, {28'h0, lfsr_q[11:8]});
      run(v, i[0], 7'(i + 1));
      rd(`ACWE_ADR_RESULT, {16'h0, r}, 32'hFFFF);
      rd(`ACWE_ADR_IFLAG, {30'h0, win(m, r, s), 1'b1}, 32'h3);
      `CHK(pos_o, 7'(i + 1))
      wr(`ACWE_ADR_ICLR, 32'h3);
    end
    wr(`ACWE_ADR_CTRL, 32'h1);
    wr(`ACWE_ADR_WMODE, 32'h2);
    wr(`ACWE_ADR_ACCUM, 32'h2);
    run(12'h040, 1'b0, 7'h0B);
    rd(`ACWE_ADR_RESULT, 32'h100, 32'hFFFF);
    rd(`ACWE_ADR_IFLAG, 32'h3, 32'h3);
    `CHK(irq_o, 1'b1)
    wr(`ACWE_ADR_IEN, 32'h0);
    `CHK(irq_o, 1'b0)
    wr(`ACWE_ADR_IEN, 32'h2);
    `CHK(irq_o, 1'b1)
    wr(`ACWE_ADR_ICLR, 32'h2);
    `CHK(irq_o, 1'b0)
    rd(`ACWE_ADR_IFLAG, 32'h1, 32'h3);
    // Sensor run: long delays, first start after enable pays the init delay
    wr(`ACWE_ADR_ACCUM, 32'h0);
    wr(`ACWE_ADR_WMODE, 32'h0);
    wr(`ACWE_ADR_CTRL, 32'h0);
    wr(`ACWE_ADR_INIT, 32'h1);
    wr(`ACWE_ADR_SAMP, 32'hFF);
    wr(`ACWE_ADR_POS, {25'h0, TEMP_SEL});
    wr(`ACWE_ADR_CTRL, 32'h1);
    t0 = ticks;
    run(12'h9C3, 1'b0, TEMP_SEL);
    `CHK(ticks - t0 > 512, 1'b1)
    `CHK(pos_o, TEMP_SEL)
    rd(`ACWE_ADR_RESULT, 32'h9C3, 32'hFFFF);
    rd(`ACWE_ADR_IFLAG, 32'h1, 32'h3);
    summarize();
  end
endmodule // adc_channel_window_event_ctrl_bench
`default_nettype wire

// ### rtl/acwe_ctrl.v
// Purpose: Channel hold, start timing, window compare and event control
//   around an analog-to-digital converter core.
// Assumes: Single clock; the converter core delivers one sample per
//   conversion phase on smp_valid_i; event input is synchronous.
// Notes: Functional notes
// Functional notes
// (R1) Single-ended uses positive select only; differential both
// (R2) Input selections tracked through a holding register
// (R3) Freeze selections; resume in final conversion cycle
// (R4) Start bit begins conversion on next edge
// (R5) Software programs long delays for temperature
// (R6) Software selects sensor, 12-bit single-ended
// (R7) Four window conditions: below, above, inside, outside
// (R8) Inside strict between; outside strict beyond
// (R9) Thresholds from registers; non-zero mode enables (mode codes 5 to 7 never set the window flag)
// (R10) Compare only final accumulated value, once
// (R11) Result-ready event is one-cycle pulse
// (R12) Event rising edge starts conversion when enabled
// (R13) Event sets start bit; completion clears it
// (R14) Interrupt while flag and enable both set
// (R15) Mode 0 unsigned single-ended; 1 signed
// (R16) Strict compare, signed in differential mode
`timescale 1ns/100ps
`default_nettype none
`include "acwe_defs.vh"

module acwe_ctrl
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Converter core
  input wire smp_valid_i,
  input wire [11:0] smp_data_i,
  output reg [6:0] positive_input_select_o,
  output reg [6:0] negative_input_select_o,
  output reg conv_busy_o,
  output reg sample_o,
  // Event side
  input wire start_event_i,
  output reg result_ready_event_o,
  // Interrupt
  output wire irq_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_INIT = 2'h1;
  localparam ST_SAMP = 2'h2;
  localparam ST_CONV = 2'h3;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg enable_q;
  reg conversion_mode_select_q;
  reg [`ACWE_ACC_W-1:0] accum_sel_q;
  reg [`ACWE_INIT_W-1:0] init_delay_field_q;
  reg [2:0] window_compare_mode_q;
  reg [`ACWE_SAMP_W-1:0] sample_length_field_q;
  reg [`ACWE_MUX_W-1:0] pos_sel_q;
  reg [`ACWE_MUX_W-1:0] neg_sel_q;
  reg start_conversion_bit_q;
  reg event_start_enable_q;
  reg [1:0] interrupt_enable_reg_q;
  reg [1:0] interrupt_flag_reg_q;
  reg [`ACWE_RES_W-1:0] conversion_result_q;
  reg [`ACWE_RES_W-1:0] window_low_threshold_q;
  reg [`ACWE_RES_W-1:0] window_high_threshold_q;
  reg event_prev_q;
  reg [1:0] state_q;
  reg [10:0] cnt_q;
  reg [7:0] nsmp_q;
  reg [`ACWE_RES_W-1:0] acc_q;
  reg held_q;
  reg init_done_q;

  wire bus_req;
  wire wr;
  wire ev_rise;
  wire go;
  wire last_cyc;
  wire last_smp;
  wire [`ACWE_RES_W-1:0] acc_next;
  wire win_hit;
  reg [1:0] flag_set;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Strict compare, signed in differential mode
  function lt16;
    input [15:0] a;
    input [15:0] b;
    input sgn;
    begin
      if (sgn)
        lt16 = $signed(a) < $signed(b); // R16
      else
        lt16 = a < b; // R16
    end
  endfunction

  function [15:0] sext12;
    input [11:0] v;
    input sgn;
    begin
      sext12 = sgn ? {{4{v[11]}}, v} : {4'h0, v}; // R15
    end
  endfunction

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Ack in the cycle after the request, then dropped for one cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = bus_req & wb_we_i & wb_sel_i[0];

  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req & ~wb_we_i)
    begin
      case (wb_adr_i)
        `ACWE_ADR_CTRL:
          wb_dat_o <= {26'h0, conversion_mode_select_q, 4'h0, enable_q};
        `ACWE_ADR_INIT: wb_dat_o <= {29'h0, init_delay_field_q};
        `ACWE_ADR_WMODE: wb_dat_o <= {29'h0, window_compare_mode_q};
        `ACWE_ADR_SAMP: wb_dat_o <= {24'h0, sample_length_field_q};
        `ACWE_ADR_POS: wb_dat_o <= {25'h0, pos_sel_q};
        `ACWE_ADR_NEG: wb_dat_o <= {25'h0, neg_sel_q};
        `ACWE_ADR_CMD: wb_dat_o <= {31'h0, start_conversion_bit_q};
        `ACWE_ADR_EVCTL: wb_dat_o <= {31'h0, event_start_enable_q};
        `ACWE_ADR_IEN: wb_dat_o <= {30'h0, interrupt_enable_reg_q};
        `ACWE_ADR_IFLAG: wb_dat_o <= {30'h0, interrupt_flag_reg_q};
        `ACWE_ADR_RESULT: wb_dat_o <= {16'h0, conversion_result_q};
        `ACWE_ADR_WLOW: wb_dat_o <= {16'h0, window_low_threshold_q};
        `ACWE_ADR_WHIGH: wb_dat_o <= {16'h0, window_high_threshold_q};
        `ACWE_ADR_STATUS: wb_dat_o <= {29'h0, held_q, state_q};
        `ACWE_ADR_ACCUM: wb_dat_o <= {29'h0, accum_sel_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_q <= 1'b0;
      conversion_mode_select_q <= 1'b0;
      accum_sel_q <= 3'h0;
      init_delay_field_q <= 3'h0;
      window_compare_mode_q <= `ACWE_WM_OFF;
      sample_length_field_q <= `ACWE_RST_BYTE;
      pos_sel_q <= 7'h00;
      neg_sel_q <= 7'h00;
      event_start_enable_q <= 1'b0;
      interrupt_enable_reg_q <= 2'h0;
      window_low_threshold_q <= `ACWE_RST_WORD;
      window_high_threshold_q <= `ACWE_RST_WORD;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `ACWE_ADR_CTRL:
        begin
          enable_q <= wb_dat_i[`ACWE_CTRL_ENABLE];
          conversion_mode_select_q <= wb_dat_i[`ACWE_CTRL_DIFF];
        end
        `ACWE_ADR_INIT: init_delay_field_q <= wb_dat_i[2:0];
        `ACWE_ADR_WMODE: window_compare_mode_q <= wb_dat_i[2:0];
        `ACWE_ADR_SAMP: sample_length_field_q <= wb_dat_i[7:0];
        `ACWE_ADR_POS: pos_sel_q <= wb_dat_i[6:0];
        `ACWE_ADR_NEG: neg_sel_q <= wb_dat_i[6:0];
        `ACWE_ADR_EVCTL: event_start_enable_q <= wb_dat_i[0];
        `ACWE_ADR_IEN: interrupt_enable_reg_q <= wb_dat_i[1:0];
        `ACWE_ADR_ACCUM: accum_sel_q <= wb_dat_i[2:0];
        `ACWE_ADR_WLOW:
        begin
          window_low_threshold_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            window_low_threshold_q[15:8] <= wb_dat_i[15:8];
        end
        `ACWE_ADR_WHIGH:
        begin
          window_high_threshold_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            window_high_threshold_q[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Start logic
  // --------------------------------------------------------------------
  assign ev_rise = start_event_i & ~event_prev_q; // R12
  assign go = enable_q & start_conversion_bit_q & (state_q == ST_IDLE);

  always @(posedge clk_i)
  begin
    if (rst_i)
      event_prev_q <= 1'b0;
    else
      event_prev_q <= start_event_i;
  end

  // Start bit set by software or event, cleared when conversion completes
  always @(posedge clk_i)
  begin
    if (rst_i)
      start_conversion_bit_q <= 1'b0;
    else if ((wr & (wb_adr_i == `ACWE_ADR_CMD) & wb_dat_i[`ACWE_CMD_START])
             | (event_start_enable_q & ev_rise)) // R13
      start_conversion_bit_q <= 1'b1; // R4
    else if (flag_set[`ACWE_IRQ_RDY])
      start_conversion_bit_q <= 1'b0; // R13
  end

  // --------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------
  assign last_cyc = (state_q == ST_CONV) & (cnt_q == 11'h001);
  assign last_smp = (nsmp_q + 8'h01) >= (8'h01 << accum_sel_q);
  assign acc_next = acc_q + sext12(smp_data_i, conversion_mode_select_q);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 11'h000;
      nsmp_q <= 8'h00;
      acc_q <= `ACWE_RST_WORD;
      held_q <= 1'b0;
      init_done_q <= 1'b0;
      conversion_result_q <= `ACWE_RST_WORD;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (go) // R4
          begin
            held_q <= 1'b1; // R3
            nsmp_q <= 8'h00;
            acc_q <= `ACWE_RST_WORD;
            if (!init_done_q && init_delay_field_q != 3'h0)
            begin
              state_q <= ST_INIT;
              cnt_q <= {init_delay_field_q, 8'h00};
            end
            else
            begin
              state_q <= ST_SAMP;
              cnt_q <= {3'h0, sample_length_field_q} + 11'h002;
            end
          end
        ST_INIT:
          if (cnt_q == 11'h001)
          begin
            init_done_q <= 1'b1;
            state_q <= ST_SAMP;
            cnt_q <= {3'h0, sample_length_field_q} + 11'h002;
          end
          else
            cnt_q <= cnt_q - 11'h001;
        ST_SAMP:
          if (cnt_q == 11'h001)
          begin
            state_q <= ST_CONV;
            cnt_q <= {3'h0, `ACWE_CONV_CYC};
          end
          else
            cnt_q <= cnt_q - 11'h001;
        ST_CONV:
          if (last_cyc)
          begin
            // Count must reach zero here or the sequencer stalls at one
            held_q <= 1'b0; // R3
            cnt_q <= 11'h000;
          end
          else if (cnt_q == 11'h000 && smp_valid_i)
          begin
            if (last_smp)
            begin
              conversion_result_q <= acc_next;
              state_q <= ST_IDLE;
            end
            else
            begin
              acc_q <= acc_next;
              nsmp_q <= nsmp_q + 8'h01;
              held_q <= 1'b1;
              state_q <= ST_SAMP;
              cnt_q <= {3'h0, sample_length_field_q} + 11'h002;
            end
          end
          else if (cnt_q != 11'h000)
            cnt_q <= cnt_q - 11'h001;
        default: state_q <= ST_IDLE;
      endcase
      if (!enable_q)
        init_done_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Input selection hold
  // --------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      positive_input_select_o <= 7'h00;
      negative_input_select_o <= 7'h00;
    end
    else if (!held_q || last_cyc) // R2 R3
    begin
      positive_input_select_o <= pos_sel_q; // R1
      negative_input_select_o <= conversion_mode_select_q ?
                                 neg_sel_q : 7'h00; // R1
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_busy_o <= 1'b0;
      sample_o <= 1'b0;
    end
    else
    begin
      conv_busy_o <= (state_q != ST_IDLE) | go;
      sample_o <= (state_q == ST_SAMP);
    end
  end

  // --------------------------------------------------------------------
  // Window comparator
  // --------------------------------------------------------------------
  // Checked once per finished accumulation only
  assign win_hit =
    (window_compare_mode_q == `ACWE_WM_BELOW) ?
      lt16(acc_next, window_low_threshold_q, conversion_mode_select_q) :
    (window_compare_mode_q == `ACWE_WM_ABOVE) ?
      lt16(window_high_threshold_q, acc_next, conversion_mode_select_q) :
    (window_compare_mode_q == `ACWE_WM_INSIDE) ?
      (lt16(window_low_threshold_q, acc_next, conversion_mode_select_q) &
       lt16(acc_next, window_high_threshold_q,
            conversion_mode_select_q)) :
    (window_compare_mode_q == `ACWE_WM_OUTSIDE) ?
      (lt16(acc_next, window_low_threshold_q, conversion_mode_select_q) |
       lt16(window_high_threshold_q, acc_next,
            conversion_mode_select_q)) :
    1'b0; // R7 R8 R9

  always @*
  begin
    flag_set = 2'h0;
    if (state_q == ST_CONV && cnt_q == 11'h000 && smp_valid_i && !last_cyc
        && last_smp)
    begin
      flag_set[`ACWE_IRQ_RDY] = 1'b1;
      flag_set[`ACWE_IRQ_WIN] = win_hit; // R10
    end
  end

  // --------------------------------------------------------------------
  // Flags, interrupt and event
  // --------------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
      interrupt_flag_reg_q <= 2'h0;
    else if (wr && wb_adr_i == `ACWE_ADR_ICLR)
      interrupt_flag_reg_q <= (interrupt_flag_reg_q & ~wb_dat_i[1:0])
                              | flag_set;
    else
      interrupt_flag_reg_q <= interrupt_flag_reg_q | flag_set;
  end

  assign irq_o = |(interrupt_flag_reg_q & interrupt_enable_reg_q); // R14

  always @(posedge clk_i)
  begin
    if (rst_i)
      result_ready_event_o <= 1'b0;
    else
      result_ready_event_o <= flag_set[`ACWE_IRQ_RDY]; // R11
  end

endmodule // acwe_ctrl
`default_nettype wire

// ### rtl/acwe_defs.vh
// Purpose: Constants for the converter channel, window and event control
// Assumes: Wishbone registers up to 16 bits wide, one aligned 32-bit word each
// Notes: Offsets are byte addresses
`ifndef ACWE_DEFS_VH
`define ACWE_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ACWE_ADR_CTRL 8'h00
`define ACWE_ADR_INIT 8'h04
`define ACWE_ADR_WMODE 8'h08
`define ACWE_ADR_SAMP 8'h0C
`define ACWE_ADR_POS 8'h10
`define ACWE_ADR_NEG 8'h14
`define ACWE_ADR_CMD 8'h18
`define ACWE_ADR_EVCTL 8'h1C
`define ACWE_ADR_IEN 8'h20
`define ACWE_ADR_IFLAG 8'h24
`define ACWE_ADR_ICLR 8'h28
`define ACWE_ADR_RESULT 8'h2C
`define ACWE_ADR_WLOW 8'h30
`define ACWE_ADR_WHIGH 8'h34
`define ACWE_ADR_STATUS 8'h38
`define ACWE_ADR_ACCUM 8'h3C

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define ACWE_CTRL_ENABLE 0
`define ACWE_CTRL_DIFF 5
`define ACWE_CMD_START 0
`define ACWE_IRQ_RDY 0
`define ACWE_IRQ_WIN 1
`define ACWE_MUX_W 7
`define ACWE_RES_W 16
`define ACWE_INIT_W 3
`define ACWE_SAMP_W 8
`define ACWE_ACC_W 3

// ----------------------------------------------------------------------
// Window compare modes
// ----------------------------------------------------------------------
`define ACWE_WM_OFF 3'h0
`define ACWE_WM_BELOW 3'h1
`define ACWE_WM_ABOVE 3'h2
`define ACWE_WM_INSIDE 3'h3
`define ACWE_WM_OUTSIDE 3'h4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ACWE_RST_BYTE 8'h00
`define ACWE_RST_WORD 16'h0000
`define ACWE_CONV_CYC 8'h0E
`define ACWE_INIT_UNIT 8'h10

`endif
